// File: multiply_and_branch_exec.sv
// multiply and program-flow executor with an AXI4-Lite register slave
// assumes a single core clock; software loads operands, then writes start
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module multiply_and_branch_exec
  import exec_pkg::*;
#(
  parameter int STACK_DEPTH = 16
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int SPW = $clog2(STACK_DEPTH);

  initial
  begin
    if (STACK_DEPTH < 2 || (1 << SPW) != STACK_DEPTH)
      $error("STACK_DEPTH must be a power of two, at least 2");
  end

  exec_if ex ();

  // software visible state
  op_type      op_q;
  logic [2:0]  bit_q;
  logic        two_word_q;
  logic [7:0]  rd_q;
  logic [7:0]  rr_q;
  logic [7:0]  io_q;
  logic [15:0] offset_q;
  logic [15:0] zptr_q;
  logic [15:0] pc_q;
  logic [7:0]  flags_q;
  logic [15:0] result_q;
  logic        busy_q;
  logic        taken_q;
  logic        bad_op_q;
  logic        stk_err_q;
  logic [2:0]  cycles_q;
  logic [2:0]  count_q;
  // return stack
  logic [15:0] stack_mem [STACK_DEPTH];
  logic [SPW-1:0] sp_q;
  // bus
  logic        aw_held_q;
  logic [7:0]  aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  // helper results
  logic [15:0] product;
  logic        prod_zero;
  logic        prod_carry;
  logic        cond_taken;
  logic [7:0]  compare_flags;

  assign ex.op      = op_q;
  assign ex.rd_val  = rd_q;
  assign ex.rr_val  = rr_q;
  assign ex.io_val  = io_q;
  assign ex.bit_sel = bit_q;
  assign ex.flags   = flags_q;

  product_unit u_product (
    .ex         (ex),
    .product    (product),
    .zero_flag  (prod_zero),
    .carry_flag (prod_carry)
  );

  condition_unit u_condition (
    .ex            (ex),
    .taken         (cond_taken),
    .compare_flags (compare_flags)
  );

  // write channel: address and data taken in either order
  logic wr_fire;
  logic start_cmd;
  logic launch_q;
  assign wr_fire   = aw_held_q && w_held_q && !s_axi_bvalid;
  assign start_cmd = wr_fire && aw_addr_q == ADDR_CONTROL && w_strb_q[1]
                   && w_data_q[CTL_START] && !busy_q;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_held_q      <= 1'b0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q[1:0] == 2'b00 && aw_addr_q <= ADDR_STATUS)
                        ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // operand registers; writes while busy are dropped so operands stay stable
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      op_q       <= product_unsigned;
      bit_q      <= 3'd0;
      two_word_q <= 1'b0;
      rd_q       <= 8'h00;
      rr_q       <= 8'h00;
      io_q       <= 8'h00;
      offset_q   <= 16'h0000;
      zptr_q     <= 16'h0000;
    end
    else if (wr_fire && !busy_q && !launch_q)
    begin
      case (aw_addr_q)
        ADDR_CONTROL:
        begin
          if (w_strb_q[0])
            op_q <= op_type'(w_data_q[CTL_OP_LSB +: 6]);
          if (w_strb_q[1])
          begin
            bit_q      <= w_data_q[CTL_BIT_LSB +: 3];
            two_word_q <= w_data_q[CTL_TWO_WORD];
          end
        end
        ADDR_OPERAND:
        begin
          if (w_strb_q[0]) rd_q <= w_data_q[OPD_RD_LSB +: 8];
          if (w_strb_q[1]) rr_q <= w_data_q[OPD_RR_LSB +: 8];
          if (w_strb_q[2]) io_q <= w_data_q[OPD_IO_LSB +: 8];
        end
        ADDR_OFFSET:
        begin
          if (w_strb_q[0]) offset_q[7:0]  <= w_data_q[7:0];
          if (w_strb_q[1]) offset_q[15:8] <= w_data_q[15:8];
        end
        ADDR_ZPTR:
        begin
          if (w_strb_q[0]) zptr_q[7:0]  <= w_data_q[7:0];
          if (w_strb_q[1]) zptr_q[15:8] <= w_data_q[15:8];
        end
        default:
        begin
        end
      endcase
    end
  end

  // operands land one edge after start, so decode runs a cycle later
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      launch_q <= 1'b0;
    else
      launch_q <= start_cmd;
  end

  // decode of cost, next pc and flags for the launched operation
  logic [2:0]  cost;
  logic [15:0] next_pc;
  logic [7:0]  next_flags;
  logic        push;
  logic        pop;
  logic        write_result;
  logic        valid_op;
  logic [15:0] rel_target;
  logic [15:0] skip_pc;
  logic [15:0] top;

  assign rel_target = pc_q + offset_q + 16'h0001;
  assign skip_pc    = pc_q + (two_word_q ? 16'h0003 : 16'h0002);
  assign top        = stack_mem[sp_q - SPW'(1)];

  always_comb
  begin
    cost         = CYC_ONE;
    next_pc      = pc_q + 16'h0001;
    next_flags   = flags_q;
    push         = 1'b0;
    pop          = 1'b0;
    write_result = 1'b0;
    valid_op     = 1'b1;
    case (op_q)
      product_unsigned, product_signed, product_mixed,
      fractional_product_unsigned, fractional_product_signed, fractional_product_mixed:
      begin
        cost                 = CYC_TWO;
        write_result         = 1'b1;
        next_flags[FLAG_Z]   = prod_zero;
        next_flags[FLAG_C]   = prod_carry;
      end
      relative_jump:
      begin
        cost    = CYC_TWO;
        next_pc = rel_target;
      end
      indirect_jump:
      begin
        cost    = CYC_TWO;
        next_pc = zptr_q;
      end
      direct_jump:
      begin
        cost    = CYC_THREE;
        next_pc = offset_q;
      end
      relative_subroutine_entry:
      begin
        cost    = CYC_THREE;
        next_pc = rel_target;
        push    = 1'b1;
      end
      indirect_subroutine_entry:
      begin
        cost    = CYC_THREE;
        next_pc = zptr_q;
        push    = 1'b1;
      end
      direct_subroutine_entry:
      begin
        cost    = CYC_FOUR;
        next_pc = offset_q;
        push    = 1'b1;
      end
      subroutine_exit, interrupt_exit:
      begin
        cost    = CYC_FOUR;
        next_pc = top;
        pop     = 1'b1;
        if (op_q == interrupt_exit)
          next_flags[FLAG_I] = 1'b1;
      end
      compare_immediate:
        next_flags = compare_flags;
      compare_skip_equal, skip_reg_bit_clear, skip_reg_bit_set,
      skip_io_bit_clear, skip_io_bit_set:
      begin
        if (cond_taken)
        begin
          cost    = two_word_q ? CYC_THREE : CYC_TWO;
          next_pc = skip_pc;
        end
      end
      default:
      begin
        if (op_q >= branch_flag_set && op_q < op_last)
        begin
          if (cond_taken)
          begin
            cost    = CYC_TWO;
            next_pc = rel_target;
          end
        end
        else
          valid_op = 1'b0;
      end
    endcase
  end

  // execution: results are held back and committed on the final cycle
  logic [15:0] pend_pc_q;
  logic [7:0]  pend_flags_q;
  logic        pend_result_q;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q        <= 1'b0;
      count_q       <= 3'd0;
      cycles_q      <= 3'd0;
      taken_q       <= 1'b0;
      bad_op_q      <= 1'b0;
      pend_pc_q     <= PC_RESET;
      pend_flags_q  <= FLAGS_RESET;
      pend_result_q <= 1'b0;
    end
    else if (launch_q)
    begin
      bad_op_q <= !valid_op;
      if (valid_op)
      begin
        busy_q        <= 1'b1;
        count_q       <= cost;
        cycles_q      <= cost;
        taken_q       <= cond_taken;
        pend_pc_q     <= next_pc;
        pend_flags_q  <= next_flags;
        pend_result_q <= write_result;
      end
    end
    else if (busy_q)
    begin
      count_q <= count_q - 3'd1;
      if (count_q == 3'd1)
        busy_q <= 1'b0;
    end
  end

  logic commit;
  assign commit = busy_q && count_q == 3'd1;

  // program counter, flags and product pair; software may overwrite pc and flags when idle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pc_q     <= PC_RESET;
      flags_q  <= FLAGS_RESET;
      result_q <= 16'h0000;
    end
    else if (commit)
    begin
      pc_q    <= pend_pc_q;
      flags_q <= pend_flags_q;
      if (pend_result_q)
        result_q <= product;
    end
    else if (wr_fire && !busy_q && !launch_q)
    begin
      if (aw_addr_q == ADDR_PC && w_strb_q[0]) pc_q[7:0]  <= w_data_q[7:0];
      if (aw_addr_q == ADDR_PC && w_strb_q[1]) pc_q[15:8] <= w_data_q[15:8];
      if (aw_addr_q == ADDR_FLAGS && w_strb_q[0]) flags_q <= w_data_q[7:0];
    end
  end

  // return stack; over- and underflow wrap and raise a sticky error
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sp_q      <= '0;
      stk_err_q <= 1'b0;
    end
    else if (launch_q && valid_op && push)
    begin
      stack_mem[sp_q] <= pc_q + ((op_q == direct_subroutine_entry) ? 16'h0002 : 16'h0001);
      sp_q            <= sp_q + SPW'(1);
      if (sp_q == SPW'(STACK_DEPTH - 1))
        stk_err_q <= 1'b1;
    end
    else if (launch_q && valid_op && pop)
    begin
      sp_q <= sp_q - SPW'(1);
      if (sp_q == '0)
        stk_err_q <= 1'b1;
    end
  end

  // read channel
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      ADDR_CONTROL: rd_word = {19'h0, two_word_q, bit_q, 1'b0, 2'b00, op_q};
      ADDR_OPERAND: rd_word = {8'h00, io_q, rr_q, rd_q};
      ADDR_OFFSET:  rd_word = {16'h0000, offset_q};
      ADDR_ZPTR:    rd_word = {16'h0000, zptr_q};
      ADDR_PC:      rd_word = {16'h0000, pc_q};
      ADDR_FLAGS:   rd_word = {24'h000000, flags_q};
      ADDR_RESULT:  rd_word = {16'h0000, result_q};
      ADDR_STATUS:  rd_word = {21'h0, cycles_q, 4'h0, stk_err_q, bad_op_q, taken_q,
                               busy_q | launch_q};
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (s_axi_araddr[1:0] == 2'b00 && s_axi_araddr <= ADDR_STATUS)
                        ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: exec_pkg.sv
// constants, field layouts and operation codes for the multiply and flow executor
// assumes one 20 MHz core clock; software drives it over an AXI4-Lite slave
// What this block does
// - Unsigned, signed and mixed multiplies write the 16-bit product to r1:r0, touch only Z and C, two cycles.
// - Fractional multiplies form the same product shifted left one bit into r1:r0, set Z and C, two cycles.
// - The indirect jump loads the program counter from Z, keeps all flags, two cycles.
// - The indirect subroutine entry jumps to Z, pushes the return point, keeps flags, three cycles.
// - Compare-skip-equal skips the next one- or two-word instruction on equality, costing 1, 2 or 3 cycles.
// - Compare-immediate subtracts a constant without storing it and sets Z, N, V, C and H in one cycle.
// - Register bit skips test one bit of a working register and skip on a match, 1, 2 or 3 cycles.
// - I/O bit skips test one bit of a low I/O register, skip on a match, keep flags, 1 to 3 cycles.
// - Flag branches test the chosen status bit and on a hit set pc to pc + k + 1, two cycles taken, one not.
// - Equal and not-equal branches go on Z one and Z zero.
// - Same-or-higher and lower branches go on C zero and C one.
// - Signed ge and lt branches go on N xor V being zero or one.
// - Half-carry branches go on H one or zero.
// - Transfer-bit branches go on T one or zero.
// - Overflow branches go on V one or zero and keep all flags.
// - Minus and plus branches go on N one or zero with the common target and cost.
package exec_pkg;

  typedef enum logic [5:0] {
    product_unsigned, product_signed, product_mixed,
    fractional_product_unsigned, fractional_product_signed, fractional_product_mixed,
    relative_jump, indirect_jump, direct_jump,
    relative_subroutine_entry, indirect_subroutine_entry, direct_subroutine_entry,
    subroutine_exit, interrupt_exit,
    compare_skip_equal, compare_immediate,
    skip_reg_bit_clear, skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set,
    branch_flag_set, branch_flag_clear, branch_equal, branch_not_equal,
    branch_same_higher, branch_lower, branch_signed_ge, branch_signed_lt,
    branch_halfcarry_set, branch_halfcarry_clear, branch_transfer_bit_set,
    branch_transfer_bit_clear, branch_overflow_set, branch_overflow_clear,
    branch_minus, branch_plus, op_last
  } op_type;

  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_OPERAND = 8'h04;
  localparam logic [7:0] ADDR_OFFSET  = 8'h08;
  localparam logic [7:0] ADDR_ZPTR    = 8'h0c;
  localparam logic [7:0] ADDR_PC      = 8'h10;
  localparam logic [7:0] ADDR_FLAGS   = 8'h14;
  localparam logic [7:0] ADDR_RESULT  = 8'h18;
  localparam logic [7:0] ADDR_STATUS  = 8'h1c;

  // control word fields
  localparam int CTL_OP_LSB   = 0;
  localparam int CTL_START    = 8;
  localparam int CTL_BIT_LSB  = 9;
  localparam int CTL_TWO_WORD = 12;
  // operand word fields
  localparam int OPD_RD_LSB   = 0;
  localparam int OPD_RR_LSB   = 8;
  localparam int OPD_IO_LSB   = 16;
  // status word fields
  localparam int STA_BUSY     = 0;
  localparam int STA_TAKEN    = 1;
  localparam int STA_BAD_OP   = 2;
  localparam int STA_STK_ERR  = 3;
  localparam int STA_CYC_LSB  = 8;

  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;

  // cycle costs
  localparam logic [2:0] CYC_ONE   = 3'd1;
  localparam logic [2:0] CYC_TWO   = 3'd2;
  localparam logic [2:0] CYC_THREE = 3'd3;
  localparam logic [2:0] CYC_FOUR  = 3'd4;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: exec_if.sv
// operands and state shared by the executor and its two helpers
// assumes the executor drives every signal from its own registers
`timescale 1ns/1ps
interface exec_if;
  import exec_pkg::*;
  op_type      op;
  logic [7:0]  rd_val;
  logic [7:0]  rr_val;
  logic [7:0]  io_val;
  logic [2:0]  bit_sel;
  logic [7:0]  flags;

  modport source (output op, rd_val, rr_val, io_val, bit_sel, flags);
  modport sink   (input op, rd_val, rr_val, io_val, bit_sel, flags);
endinterface

// File: product_unit.sv
// 8x8 multiplier for all six product operations, combinational
// assumes operands are held stable by the executor for the whole operation
`timescale 1ns/1ps
module product_unit
  import exec_pkg::*;
(
  // operands
  exec_if.sink       ex,
  // result
  output logic [15:0] product,
  output logic        zero_flag,
  output logic        carry_flag
);
  logic signed [9:0]  a_ext;
  logic signed [9:0]  b_ext;
  logic signed [19:0] full;
  logic [15:0]        raw;
  logic               frac;

  always_comb
  begin
    frac  = 1'b0;
    a_ext = {2'b00, ex.rd_val};
    b_ext = {2'b00, ex.rr_val};
    case (ex.op)
      product_signed, fractional_product_signed:
      begin
        a_ext = {{2{ex.rd_val[7]}}, ex.rd_val};
        b_ext = {{2{ex.rr_val[7]}}, ex.rr_val};
      end
      product_mixed, fractional_product_mixed:
        a_ext = {{2{ex.rd_val[7]}}, ex.rd_val};
      default:
        a_ext = {2'b00, ex.rd_val};
    endcase
    case (ex.op)
      fractional_product_unsigned, fractional_product_signed, fractional_product_mixed:
        frac = 1'b1;
      default:
        frac = 1'b0;
    endcase
  end

  assign full = a_ext * b_ext;
  assign raw  = full[15:0];
  // carry is the product's top bit before the fractional shift
  assign product    = frac ? {raw[14:0], 1'b0} : raw;
  assign carry_flag = raw[15];
  assign zero_flag  = (product == 16'h0000);
endmodule

// File: condition_unit.sv
// branch and skip condition decode plus the compare-immediate flags
// assumes flags follow the usual order C Z N V S H T I from bit 0
`timescale 1ns/1ps
module condition_unit
  import exec_pkg::*;
(
  // operands and flags
  exec_if.sink       ex,
  // decisions
  output logic       taken,
  output logic [7:0] compare_flags
);
  logic [7:0] diff;
  logic       sel_bit;

  assign diff    = ex.rd_val - ex.rr_val;
  assign sel_bit = ex.flags[ex.bit_sel];

  always_comb
  begin
    compare_flags = ex.flags;
    compare_flags[FLAG_Z] = (diff == 8'h00);
    compare_flags[FLAG_N] = diff[7];
    compare_flags[FLAG_V] = (ex.rd_val[7] & ~ex.rr_val[7] & ~diff[7])
                          | (~ex.rd_val[7] & ex.rr_val[7] & diff[7]);
    compare_flags[FLAG_C] = (~ex.rd_val[7] & ex.rr_val[7]) | (ex.rr_val[7] & diff[7])
                          | (diff[7] & ~ex.rd_val[7]);
    compare_flags[FLAG_H] = (~ex.rd_val[3] & ex.rr_val[3]) | (ex.rr_val[3] & diff[3])
                          | (diff[3] & ~ex.rd_val[3]);
  end

  always_comb
  begin
    case (ex.op)
      compare_skip_equal:        taken = (ex.rd_val == ex.rr_val);
      skip_reg_bit_clear:        taken = ~ex.rd_val[ex.bit_sel];
      skip_reg_bit_set:          taken = ex.rd_val[ex.bit_sel];
      skip_io_bit_clear:         taken = ~ex.io_val[ex.bit_sel];
      skip_io_bit_set:           taken = ex.io_val[ex.bit_sel];
      branch_flag_set:           taken = sel_bit;
      branch_flag_clear:         taken = ~sel_bit;
      branch_equal:              taken = ex.flags[FLAG_Z];
      branch_not_equal:          taken = ~ex.flags[FLAG_Z];
      branch_same_higher:        taken = ~ex.flags[FLAG_C];
      branch_lower:              taken = ex.flags[FLAG_C];
      branch_signed_ge:          taken = ~(ex.flags[FLAG_N] ^ ex.flags[FLAG_V]);
      branch_signed_lt:          taken = ex.flags[FLAG_N] ^ ex.flags[FLAG_V];
      branch_halfcarry_set:      taken = ex.flags[FLAG_H];
      branch_halfcarry_clear:    taken = ~ex.flags[FLAG_H];
      branch_transfer_bit_set:   taken = ex.flags[FLAG_T];
      branch_transfer_bit_clear: taken = ~ex.flags[FLAG_T];
      branch_overflow_set:       taken = ex.flags[FLAG_V];
      branch_overflow_clear:     taken = ~ex.flags[FLAG_V];
      branch_minus:              taken = ex.flags[FLAG_N];
      branch_plus:               taken = ~ex.flags[FLAG_N];
      default:                   taken = 1'b0;
    endcase
  end
endmodule

// File: multiply_and_branch_exec_asserts.sv
// bus handshake checks for the executor register slave
// assumes binding into the executor top
`timescale 1ns/1ps
module multiply_and_branch_exec_asserts
  import exec_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp});
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_aw_pulse;
    s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
  property p_ar_pulse;
    s_axi_arready |=> !s_axi_arready;
  endproperty
  a_ar_pulse: assert property (p_ar_pulse) else $error("arready held");
  property p_aw_taken;
    s_axi_awvalid |-> ##[0:4] s_axi_awready;
  endproperty
  a_aw_taken: assert property (p_aw_taken) else $error("write address not taken");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read not answered");
  property p_b_legal;
    s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR;
  endproperty
  a_b_legal: assert property (p_b_legal) else $error("bad bresp code");
  property p_r_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c
      |-> ##[1:2] s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_r_unmapped: assert property (p_r_unmapped) else $error("unmapped read not refused");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_SLVERR);
  cover property (s_axi_arvalid && s_axi_arready);
endmodule

bind multiply_and_branch_exec multiply_and_branch_exec_asserts i_multiply_and_branch_exec_asserts (
  .core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);

// File: multiply_and_branch_exec_tb_top.sv
// register-level bench for the multiply and flow executor
// assumes the register map and op codes of exec_pkg
`timescale 1ns/1ps
module multiply_and_branch_exec_tb_top;
  import exec_pkg::*;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
  logic        core_clk = 0, rst = 1;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, st, v;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [7:0]  pats [4] = '{8'h00, 8'hff, 8'h29, 8'h56};
  int          n_errors = 0, n_checks = 0, cyc = 0;
  logic        t;
  multiply_and_branch_exec i_multiply_and_branch_exec (.core_clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  initial forever #25 core_clk = ~core_clk;
  task conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      conclude();
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // pc set to 0x100 before each op
  task run(input op_type op, input logic [3:0] b, input logic [31:0] opd, off,
           input logic [7:0] f);
    wr(ADDR_OPERAND, opd);
    wr(ADDR_OFFSET, off);
    wr(ADDR_ZPTR, off);
    wr(ADDR_PC, 32'h100);
    wr(ADDR_FLAGS, {24'h0, f});
    wr(ADDR_CONTROL, {19'h0, b, 1'b1, 2'b0, op});
    do rd(ADDR_STATUS, st); while (st[STA_BUSY] !== 1'b0);
  endtask
  task chk(input logic [15:0] pc, input logic [2:0] cy);
    rd(ADDR_PC, v);
    `CHK(v[15:0], pc)
    `CHK(st[10:8], cy)
  endtask
  task mul(input op_type op, input logic [31:0] opd, input logic [7:0] f, fx,
           input logic [15:0] res);
    run(op, 4'h0, opd, 32'h0, f);
    chk(16'h101, CYC_TWO);
    rd(ADDR_RESULT, v);
    `CHK(v[15:0], res)
    rd(ADDR_FLAGS, v);
    `CHK(v[7:0], fx)
  endtask
  function automatic logic br(op_type o, logic [7:0] f);
    case (o)
      branch_flag_set, branch_flag_clear, branch_overflow_set, branch_overflow_clear:
        br = f[FLAG_V];
      branch_equal, branch_not_equal: br = f[FLAG_Z];
      branch_same_higher, branch_lower: br = !f[FLAG_C];
      branch_signed_ge, branch_signed_lt: br = f[FLAG_N] ~^ f[FLAG_V];
      branch_halfcarry_set, branch_halfcarry_clear: br = f[FLAG_H];
      branch_transfer_bit_set, branch_transfer_bit_clear: br = f[FLAG_T];
      default: br = f[FLAG_N];
    endcase
    if (o[0]) br = !br;
  endfunction
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 0;
    rd(ADDR_PC, v);
    `CHK(v[15:0], PC_RESET)
    rd(8'h20, v);
    `CHK(rs, RESP_SLVERR)
    mul(product_unsigned, 32'hffff, 8'hfc, 8'hfd, 16'hfe01);
    mul(product_signed, 32'hffff, 8'h00, 8'h00, 16'h0001);
    mul(fractional_product_unsigned, 32'h8080, 8'hff, 8'hfc, 16'h8000);
    run(indirect_jump, 4'h0, 32'h0, 32'h1234, 8'h00);
    chk(16'h1234, CYC_TWO);
    run(indirect_subroutine_entry, 4'h0, 32'h0, 32'h0234, 8'h00);
    chk(16'h0234, CYC_THREE);
    run(subroutine_exit, 4'h0, 32'h0, 32'h0, 8'h00);
    chk(16'h0101, CYC_FOUR);
    run(relative_jump, 4'h0, 32'h0, 32'h0005, 8'h00);
    chk(16'h0106, CYC_TWO);
    run(direct_jump, 4'h0, 32'h0, 32'h0abc, 8'h00);
    chk(16'h0abc, CYC_THREE);
    run(compare_skip_equal, 4'h8, 32'h5555, 32'h0, 8'h00);
    chk(16'h0103, CYC_THREE);
    run(compare_skip_equal, 4'h0, 32'h5455, 32'h0, 8'h00);
    chk(16'h0101, CYC_ONE);
    run(compare_immediate, 4'h0, 32'h2010, 32'h0, 8'h00);
    chk(16'h0101, CYC_ONE);
    rd(ADDR_FLAGS, v);
    `CHK(v[7:0], 8'h05)
    run(skip_reg_bit_set, 4'h7, 32'h0080, 32'h0, 8'h00);
    chk(16'h0102, CYC_TWO);
    run(skip_io_bit_clear, 4'h8, 32'hfe0000, 32'h0, 8'h00);
    chk(16'h0103, CYC_THREE);
    for (int o = branch_flag_set; o <= branch_plus; o++)
      foreach (pats[i])
      begin
        run(op_type'(o), 4'h3, 32'h0, 32'hfffe, pats[i]);
        t = br(op_type'(o), pats[i]);
        chk(t ? 16'h00ff : 16'h0101, t ? CYC_TWO : CYC_ONE);
        rd(ADDR_FLAGS, v);
        `CHK(v[7:0], pats[i])
      end
    conclude();
  end
endmodule
